// File: src/i2c_slave_map.svh
`ifndef I2C_SLAVE_MAP_SVH
`define I2C_SLAVE_MAP_SVH

// Seven-bit calling address answered by this slave.
`define SLAVE_ADDR 7'h33
// Value of the direction bit that asks the slave to transmit.
`define RW_READ 1'b1
// Count value on the eighth bit of a byte.
`define LAST_BIT 4'h7
// Count loaded at START, so that the clock fall that ends the START is not taken as a bit.
`define ADDR_SKIP 4'hF
// Width of the clock-stretch counter.
`define HOLD_W 4

// Local clock period and the serial clock rate that the slave must keep up with.
`define CLK_PERIOD_NS 10
`define BUS_MAX_KHZ 100
// Least time the slave holds the serial clock low after each byte that the slave acknowledges.
`define HOLD_NS 80
// Least time rounds up to whole clock cycles.
`define HOLD_CYC ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Idle level of both lines, and the reset value of the sampling chain.
`define LINE_IDLE 1'b1

`endif

// File: src/i2c_slave_pkg.sv
`default_nettype none

package i2c_slave_pkg;

    // Gray codes along the write path; on the read path ST_ADDR_ACK to ST_TX changes three bits.
    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_ADDR     = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_REG_RX   = 4'h2,
        ST_REG_ACK  = 4'h6,
        ST_DATA_RX  = 4'h7,
        ST_DATA_ACK = 4'h5,
        ST_TX       = 4'h4,
        ST_TX_ACK   = 4'hC,
        ST_WAIT     = 4'hD
    } slave_state_t;

endpackage : i2c_slave_pkg

`default_nettype wire

// File: src/i2c_line_if.sv
`timescale 1ns/1ns
`default_nettype none

interface i2c_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    modport sampler (
        output scl,
        output sda,
        output scl_rise,
        output scl_fall,
        output start_det,
        output stop_det
    );

    modport core (
        input scl,
        input sda,
        input scl_rise,
        input scl_fall,
        input start_det,
        input stop_det
    );
endinterface : i2c_line_if

`default_nettype wire

// File: src/i2c_line_sampler.sv
`timescale 1ns/1ns
`default_nettype none

`include "i2c_slave_map.svh"

module i2c_line_sampler (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    i2c_line_if.sampler ln
);
    import i2c_slave_pkg::*;

    logic [1:0] pin;
    logic [1:0] filt;
    logic [1:0] prev;

    assign pin = {sda_in, scl_in};

    // Both lines come from the far side; a change counts once the second and third stages agree.
    for (genvar i = 0; i < 2; i++) begin : g_line
        logic s1_r;
        logic s2_r;
        logic s3_r;
        logic filt_r;
        logic prev_r;
        logic filt_nxt;

        always_comb begin
            filt_nxt = (s2_r == s3_r) ? s3_r : filt_r;
        end

        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                s1_r <= `LINE_IDLE;
                s2_r <= `LINE_IDLE;
                s3_r <= `LINE_IDLE;
                filt_r <= `LINE_IDLE;
                prev_r <= `LINE_IDLE;
            end else begin
                s1_r <= pin[i];
                s2_r <= s1_r;
                s3_r <= s2_r;
                filt_r <= filt_nxt;
                prev_r <= filt_r;
            end
        end

        assign filt[i] = filt_r;
        assign prev[i] = prev_r;
    end

    // At 100 MHz a 100 kHz bus gives hundreds of samples per phase, so no edge is missed.
    assign ln.scl = filt[0];
    assign ln.sda = filt[1];
    assign ln.scl_rise = filt[0] & ~prev[0];
    assign ln.scl_fall = ~filt[0] & prev[0];
    assign ln.start_det = filt[0] & prev[0] & prev[1] & ~filt[1];
    assign ln.stop_det = filt[0] & prev[0] & ~prev[1] & filt[1];

endmodule : i2c_line_sampler

`default_nettype wire

// File: src/i2c_register_access_slave.sv
`timescale 1ns/1ns
`default_nettype none

`include "i2c_slave_map.svh"

module i2c_register_access_slave (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    input wire logic [7:0] reg_rdata
);
    import i2c_slave_pkg::*;

    localparam logic [`HOLD_W-1:0] HOLD_LOAD = `HOLD_W'(`HOLD_CYC);

    i2c_line_if ln ();

    i2c_line_sampler u_sampler (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ln(ln)
    );

    slave_state_t st_r;
    slave_state_t st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic rw_r;
    logic rw_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic scl_oe_r;
    logic scl_oe_nxt;
    logic [`HOLD_W-1:0] hold_r;
    logic [`HOLD_W-1:0] hold_nxt;
    logic [7:0] reg_addr_r;
    logic [7:0] reg_addr_nxt;
    logic [7:0] reg_wdata_r;
    logic [7:0] reg_wdata_nxt;
    logic reg_wr_r;
    logic reg_wr_nxt;
    logic drive_low_r;
    logic bus_event;

    function automatic logic is_rx(input slave_state_t s);
        is_rx = (s == ST_ADDR) || (s == ST_REG_RX) || (s == ST_DATA_RX);
    endfunction : is_rx

    // Start and stop outrank any clock edge seen in the same cycle.
    assign bus_event = ln.start_det | ln.stop_det;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        rw_nxt = rw_r;
        sda_oe_nxt = sda_oe_r;
        // The stretch counter runs down by itself; only an acknowledged ninth clock reloads it.
        hold_nxt = (hold_r != '0) ? hold_r - `HOLD_W'(1) : hold_r;
        reg_addr_nxt = reg_addr_r;
        reg_wdata_nxt = reg_wdata_r;
        reg_wr_nxt = 1'b0;
        if (ln.stop_det) begin
            st_nxt = ST_IDLE;
            sda_oe_nxt = 1'b0;
            hold_nxt = '0;
        end else if (ln.start_det) begin
            st_nxt = ST_ADDR;
            // The master pulls the clock low once after every START, and that fall carries no bit.
            // The count therefore starts one step early, and that fall only wraps it to zero.
            cnt_nxt = `ADDR_SKIP;
            sda_oe_nxt = 1'b0;
            hold_nxt = '0;
        end else if (ln.scl_fall) begin
            if (is_rx(st_r)) begin
                sh_nxt = {sh_r[6:0], ln.sda};
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == `LAST_BIT) begin
                    cnt_nxt = 4'h0;
                    if (st_r == ST_ADDR) begin
                        if (sh_r[6:0] == `SLAVE_ADDR) begin
                            st_nxt = ST_ADDR_ACK;
                            rw_nxt = ln.sda;
                            sda_oe_nxt = 1'b1;
                        end else begin
                            st_nxt = ST_WAIT;
                        end
                    end else if (st_r == ST_REG_RX) begin
                        st_nxt = ST_REG_ACK;
                        sda_oe_nxt = 1'b1;
                    end else begin
                        st_nxt = ST_DATA_ACK;
                        sda_oe_nxt = 1'b1;
                    end
                end
            end else if (st_r == ST_ADDR_ACK) begin
                hold_nxt = HOLD_LOAD;
                if (rw_r == `RW_READ) begin
                    st_nxt = ST_TX;
                    sh_nxt = reg_rdata;
                    sda_oe_nxt = ~reg_rdata[7];
                end else begin
                    st_nxt = ST_REG_RX;
                    sda_oe_nxt = 1'b0;
                end
            end else if (st_r == ST_REG_ACK) begin
                hold_nxt = HOLD_LOAD;
                st_nxt = ST_DATA_RX;
                sda_oe_nxt = 1'b0;
                reg_addr_nxt = sh_r;
            end else if (st_r == ST_DATA_ACK) begin
                hold_nxt = HOLD_LOAD;
                st_nxt = ST_WAIT;
                sda_oe_nxt = 1'b0;
                reg_wdata_nxt = sh_r;
                reg_wr_nxt = 1'b1;
            end else if (st_r == ST_TX) begin
                cnt_nxt = cnt_r + 4'h1;
                if (cnt_r == `LAST_BIT) begin
                    cnt_nxt = 4'h0;
                    st_nxt = ST_TX_ACK;
                    sda_oe_nxt = 1'b0;
                end else begin
                    sh_nxt = {sh_r[6:0], 1'b0};
                    sda_oe_nxt = ~sh_r[6];
                end
            end else if (st_r == ST_TX_ACK) begin
                // Only one byte per transaction, so an acknowledge from the master ends it too.
                st_nxt = ST_WAIT;
                sda_oe_nxt = 1'b0;
            end
        end
        // Holding the clock after each byte the slave acknowledges gives the register file time to settle.
        scl_oe_nxt = (hold_nxt != '0);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            rw_r <= 1'b0;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
            hold_r <= '0;
            reg_addr_r <= 8'h00;
            reg_wdata_r <= 8'h00;
            reg_wr_r <= 1'b0;
            drive_low_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            rw_r <= rw_nxt;
            sda_oe_r <= sda_oe_nxt;
            scl_oe_r <= scl_oe_nxt;
            hold_r <= hold_nxt;
            reg_addr_r <= reg_addr_nxt;
            reg_wdata_r <= reg_wdata_nxt;
            reg_wr_r <= reg_wr_nxt;
            drive_low_r <= 1'b0;
        end
    end

    // Open-drain pins: the output level is always low and only the enable moves.
    assign scl_out = drive_low_r;
    assign sda_out = drive_low_r;
    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;
    assign reg_addr = reg_addr_r;
    assign reg_wdata = reg_wdata_r;
    assign reg_wr = reg_wr_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence addr_match_s;
        st_r == ST_ADDR && ln.scl_fall && !bus_event && cnt_r == `LAST_BIT && sh_r[6:0] == `SLAVE_ADDR;
    endsequence

    sequence addr_miss_s;
        st_r == ST_ADDR && ln.scl_fall && !bus_event && cnt_r == `LAST_BIT && sh_r[6:0] != `SLAVE_ADDR;
    endsequence

    sequence held_low_s;
        scl_oe_r[*8] ##1 !scl_oe_r;
    endsequence

    sequence tx_shift_s;
        st_r == ST_TX && ln.scl_fall && !bus_event && cnt_r != `LAST_BIT;
    endsequence

    stop_release_a: assert property (ln.stop_det |=> !sda_oe_r && !scl_oe_r && st_r == ST_IDLE)
        else $error("lines not released after stop");

    start_restart_a: assert property (ln.start_det && !ln.stop_det |=> st_r == ST_ADDR && cnt_r == `ADDR_SKIP)
        else $error("start did not restart address phase");

    addr_ack_a: assert property (addr_match_s |=> st_r == ST_ADDR_ACK && sda_oe_r)
        else $error("matching address not acknowledged");

    addr_nack_a: assert property (addr_miss_s |=> st_r == ST_WAIT && !sda_oe_r)
        else $error("foreign address was acknowledged");

    bit_sample_a: assert property (is_rx(st_r) && ln.scl_fall && !bus_event |=> sh_r[0] == $past(ln.sda))
        else $error("bit not taken at clock fall");

    tx_msb_a: assert property (st_r == ST_ADDR_ACK && rw_r && ln.scl_fall && !bus_event
        |=> st_r == ST_TX && sda_oe_r == !$past(reg_rdata[7]))
        else $error("transmit did not start with msb");

    stretch_len_a: assert property ($rose(scl_oe_r) |-> held_low_s)
        else $error("clock stretch length wrong");

    ack_stretch_a: assert property ((st_r == ST_REG_ACK || st_r == ST_DATA_ACK) && ln.scl_fall && !bus_event
        |=> !sda_oe_r && scl_oe_r)
        else $error("ack not released or clock not held");

    data_stable_a: assert property ($changed(sda_oe_r) |-> $past(ln.scl_fall) || $past(bus_event))
        else $error("data line moved outside clock low start");

    master_nak_a: assert property (st_r == ST_TX_ACK && ln.scl_fall && !bus_event |=> st_r == ST_WAIT && !sda_oe_r)
        else $error("data line not released after master nak");

    write_pulse_a: assert property (reg_wr_r |-> $past(st_r) == ST_DATA_ACK ##1 !reg_wr_r)
        else $error("register write pulse misplaced");

    one_byte_a: assert property (st_r == ST_WAIT && !bus_event |=> st_r == ST_WAIT && !sda_oe_r)
        else $error("second byte accepted in one transaction");

    // The checks below follow each byte from the fall after START through its bits and acknowledge to the hand-over at the port; the last covers idle.
    first_fall_a: assert property (st_r == ST_ADDR && cnt_r == `ADDR_SKIP && ln.scl_fall && !bus_event
        |=> st_r == ST_ADDR && cnt_r == 4'h0)
        else $error("fall after start counted as a bit");

    rw_take_a: assert property (addr_match_s |=> rw_r == $past(ln.sda))
        else $error("direction bit not taken");

    reg_ack_a: assert property (st_r == ST_REG_RX && ln.scl_fall && !bus_event && cnt_r == `LAST_BIT
        |=> st_r == ST_REG_ACK && sda_oe_r)
        else $error("register byte not acknowledged");

    data_ack_a: assert property (st_r == ST_DATA_RX && ln.scl_fall && !bus_event && cnt_r == `LAST_BIT
        |=> st_r == ST_DATA_ACK && sda_oe_r)
        else $error("data byte not acknowledged");

    reg_addr_take_a: assert property (st_r == ST_REG_ACK && ln.scl_fall && !bus_event
        |=> reg_addr_r == $past(sh_r))
        else $error("register address not taken");

    write_data_a: assert property (st_r == ST_DATA_ACK && ln.scl_fall && !bus_event
        |=> reg_wr_r && reg_wdata_r == $past(sh_r))
        else $error("written byte not handed over");

    tx_bit_a: assert property (tx_shift_s |=> sda_oe_r == !$past(sh_r[6]))
        else $error("transmitted bit out of order");

    tx_release_a: assert property (st_r == ST_TX && ln.scl_fall && !bus_event && cnt_r == `LAST_BIT
        |=> st_r == ST_TX_ACK && !sda_oe_r)
        else $error("data line not released for master ack");

    idle_quiet_a: assert property (st_r == ST_IDLE |-> !sda_oe_r && !scl_oe_r)
        else $error("line driven while idle");

endmodule : i2c_register_access_slave

`default_nettype wire

// File: tb/i2c_bus_master_model.sv
`timescale 1ns/1ns
`default_nettype none

// Far-side bus master; a 1 on scl_m or sda_m releases that line to the pull-up.
module i2c_bus_master_model (
    input wire logic scl,
    input wire logic sda,
    output logic scl_m,
    output logic sda_m
);
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end

    // The high phase is timed from the real rise, so a stretching slave only slows the bit.
    task bit_io(input logic b, output logic r);
        #40 sda_m = b;
        #40 scl_m = 1'b1;
        wait (scl === 1'b1);
        #45 r = sda;
        scl_m = 1'b0;
    endtask : bit_io

    task byte_io(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
    endtask : byte_io

    task start;
        if (scl_m == 1'b0) begin
            #40 sda_m = 1'b1;
            #40 scl_m = 1'b1;
            wait (scl === 1'b1);
            #45;
        end
        sda_m = 1'b0;
        #45 scl_m = 1'b0;
    endtask : start

    task stop;
        #40 sda_m = 1'b0;
        #40 scl_m = 1'b1;
        wait (scl === 1'b1);
        #45 sda_m = 1'b1;
        #125;
    endtask : stop
endmodule : i2c_bus_master_model

`default_nettype wire

// File: tb/i2c_register_access_slave_tb.sv
`timescale 1ns/1ns
`default_nettype none

module i2c_register_access_slave_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic scl_m, sda_m, scl, sda, scl_out, scl_oe, sda_out, sda_oe, reg_wr;
    logic [7:0] reg_addr, reg_wdata, last_a, last_d;
    logic [7:0] reg_rdata = 8'h00;
    logic [7:0] mem [256];
    logic [7:0] exp_mem [256];
    int n_errors = 0;
    int tests_run = 0;
    int n_wr = 0;
    int n_hold = 0;
    int exp_hold = 0;
    time t_hold = 0;

    // Open-drain wires with pull-ups: low when any party pulls.
    assign scl = scl_m & (scl_oe ? scl_out : 1'b1);
    assign sda = sda_m & (sda_oe ? sda_out : 1'b1);

    always #5 mclk = ~mclk;

    i2c_register_access_slave u_dut (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl_in(scl),
        .scl_out(scl_out),
        .scl_oe(scl_oe),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rdata(reg_rdata)
    );

    i2c_bus_master_model u_master (
        .scl(scl),
        .sda(sda),
        .scl_m(scl_m),
        .sda_m(sda_m)
    );

    task automatic chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    always @(posedge mclk) begin
        if (reg_wr === 1'b1) begin
            mem[reg_addr] <= reg_wdata;
            last_a <= reg_addr;
            last_d <= reg_wdata;
            n_wr <= n_wr + 1;
        end
    end

    always @(negedge mclk) reg_rdata <= mem[reg_addr];

    always @(posedge scl_oe) t_hold = $time;
    always @(negedge scl_oe) begin
        if (rst_n === 1'b1) begin
            n_hold++;
            chk_byte("stretch cycles", 8'h08, 8'(($time - t_hold) / 10));
        end
    end

    // The data drive may only move while the clock wire is low.
    always @(sda_oe) begin
        if (scl === 1'b1 && rst_n === 1'b1) begin
            n_errors++;
            $display("unexpected data drive edge: expected none while clock high seen %b", sda_oe);
        end
    end

    // Mode 0 is a plain write, 1 adds a byte past the data, 2 stops right after the register byte.
    task automatic wr_txn(input logic [7:0] ra, input logic [7:0] d, input int mode);
        logic [8:0] rx;
        int w0;
        w0 = n_wr;
        u_master.start();
        u_master.byte_io({8'h66, 1'b1}, rx);
        chk_bit("address ack", 1'b0, rx[0]);
        u_master.byte_io({ra, 1'b1}, rx);
        chk_bit("register ack", 1'b0, rx[0]);
        if (mode != 2) begin
            u_master.byte_io({d, 1'b1}, rx);
            chk_bit("data ack", 1'b0, rx[0]);
            exp_mem[ra] = d;
        end
        if (mode == 1) begin
            u_master.byte_io({~d, 1'b1}, rx);
            chk_bit("extra byte ack", 1'b1, rx[0]);
        end
        u_master.stop();
        exp_hold += (mode == 2) ? 2 : 3;
        chk_byte("write strobes", (mode == 2) ? 8'h00 : 8'h01, 8'(n_wr - w0));
        chk_bit("clock released", 1'b0, scl_oe);
        chk_bit("data released", 1'b0, sda_oe);
        if (mode != 2) begin
            chk_byte("written address", ra, last_a);
            chk_byte("written data", d, last_d);
        end
    endtask : wr_txn

    task automatic rd_txn(input logic [7:0] ra);
        logic [8:0] rx;
        u_master.start();
        u_master.byte_io({8'h66, 1'b1}, rx);
        chk_bit("address ack", 1'b0, rx[0]);
        u_master.byte_io({ra, 1'b1}, rx);
        chk_bit("register ack", 1'b0, rx[0]);
        u_master.start();
        u_master.byte_io({8'h67, 1'b1}, rx);
        chk_bit("read address ack", 1'b0, rx[0]);
        u_master.byte_io(9'h1FF, rx);
        chk_byte("read data", exp_mem[ra], rx[8:1]);
        #60 chk_bit("line after nak", 1'b1, sda);
        u_master.stop();
        exp_hold += 3;
    endtask : rd_txn

    task automatic bad_txn(input logic [6:0] a, input logic rw);
        logic [8:0] rx;
        int w0;
        w0 = n_wr;
        u_master.start();
        u_master.byte_io({a, rw, 1'b1}, rx);
        chk_bit("foreign address ack", 1'b1, rx[0]);
        u_master.byte_io({8'($urandom), 1'b1}, rx);
        chk_bit("ignored byte ack", 1'b1, rx[0]);
        u_master.stop();
        chk_byte("foreign strobes", 8'h00, 8'(n_wr - w0));
    endtask : bad_txn

    task automatic results;
        $display("checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    initial begin
        #800_000;
        n_errors++;
        $display("unexpected watchdog: expected end of tests seen hang");
        results();
    end

    initial begin
        logic [7:0] ra;
        logic [6:0] a;
        void'($urandom(23763));
        for (int i = 0; i < 256; i++) begin
            exp_mem[i] = 8'($urandom);
            mem[i] = exp_mem[i];
        end
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        chk_bit("idle clock drive", 1'b0, scl_oe);
        chk_bit("idle data drive", 1'b0, sda_oe);
        wr_txn(8'h00, 8'hFF, 0);
        wr_txn(8'hFF, 8'h00, 1);
        rd_txn(8'h00);
        rd_txn(8'hFF);
        for (int i = 0; i < 6; i++) begin
            ra = 8'($urandom);
            wr_txn(ra, 8'($urandom), i % 3);
            rd_txn(ra);
        end
        bad_txn(7'h32, 1'b0);
        bad_txn(7'h73, 1'b1);
        for (int i = 0; i < 4; i++) begin
            a = 7'($urandom);
            if (a == 7'h33) begin
                a = 7'h34;
            end
            bad_txn(a, i[0]);
        end
        rd_txn(ra);
        chk_byte("stretch count", 8'(exp_hold), 8'(n_hold));
        results();
    end
endmodule : i2c_register_access_slave_tb

`default_nettype wire
